// ==== common/wdrc_defines.vh ====
// constants for the watchdog and reset control block
// assumes a 25 MHz system clock and a wishbone bus with 32-bit data
`ifndef WDRC_DEFINES_VH
`define WDRC_DEFINES_VH

// register byte addresses
`define WDRC_ADR_CTRL 4'h0
`define WDRC_ADR_FLAGS 4'h4
`define WDRC_ADR_STAT 4'h8
`define WDRC_ADR_CFG 4'hc

// watchdog_control layout and power-on value
`define WDRC_CTRL_RST 8'h53
`define WDRC_KEY_MSB 7
`define WDRC_KEY_LSB 3
`define WDRC_TSEL_MSB 2
`define WDRC_TSEL_LSB 0
`define WDRC_KEY_OFF 5'h15
`define WDRC_KEY_ON 5'h0a

// reset_cause_flags layout
`define WDRC_FLAG_KEY 0
`define WDRC_FLAGS_RST 1'b0

// status register layout
`define WDRC_STAT_TO 0
`define WDRC_STAT_PDF 1
`define WDRC_STAT_EN 2
`define WDRC_STAT_FAULT 3

// config register layout
`define WDRC_CFG_FSS 0
`define WDRC_CFG_RST 1'b0

// sub-clock ticks between key fault and its reset
`define WDRC_FAULT_TICKS 2'd2

// widths
`define WDRC_CNT_W 18
`define WDRC_DLY_W 21

// timing
`define WDRC_CLK_MHZ 25
`define WDRC_T_EXT_US 16700
`define WDRC_T_POR_US 50000

`endif

// ==== hw/wdrc_top.v ====
// watchdog timer with keyed enable, timeout select and reset sequencing
// assumes sub-clock ticks arrive as one-cycle pulses synchronous to clk_i,
// and that rst_i is the power-on reset of the device
//
// Contract
// - key 10101 disables, 01010 enables, else reset
// - key field powers up as 01010
// - timeout select picks 2^8 to 2^18 ticks
// - bad key sets fault flag, reset later
// - fault flag cleared only by software write
// - normal overflow resets device, sets timeout flag
// - sleep overflow sets flags, resets pc/sp only
// - four events clear the watchdog count
// - flag register bits 7..3 read zero
// - power-on resets pc, ports become inputs
// - reset pin low restarts from address zero
// - pin release waits restart delay 16.7ms
// - power-on waits start-up delay 50ms
// - sub clock from crystal or rc
// - power-down flag clear/set by events
// - halt clears count and timeout flag
//
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/1ns
`include "wdrc_defines.vh"

module wdrc_top #(
    parameter EXT_DELAY_CYC = `WDRC_T_EXT_US * `WDRC_CLK_MHZ,
    parameter POR_DELAY_CYC = `WDRC_T_POR_US * `WDRC_CLK_MHZ
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire lxt_tick_i,
    input wire internal_low_speed_rc_tick_i,
    input wire clear_wdt_i,
    input wire halt_i,
    input wire sleep_i,
    input wire reset_pin_en_i,
    input wire ext_reset_n_i,
    output reg sys_rst_o,
    output reg port_init_o,
    output reg pc_sp_rst_o,
    output reg timeout_flag_o,
    output reg power_down_flag_o
);

    localparam S_RUN = 3'b001;
    localparam S_HOLD = 3'b010;
    localparam S_DELAY = 3'b100;

    localparam [`WDRC_DLY_W-1:0] EXT_DLY = EXT_DELAY_CYC[`WDRC_DLY_W-1:0];
    localparam [`WDRC_DLY_W-1:0] POR_DLY = POR_DELAY_CYC[`WDRC_DLY_W-1:0];
    localparam [`WDRC_DLY_W-1:0] DLY_ONE = 1;

    reg [2:0] state_q;
    reg [`WDRC_DLY_W-1:0] dly_q;
    reg [7:0] ctrl_q;
    reg key_fault_q;
    reg fss_q;
    reg fault_pend_q;
    reg [1:0] fault_cnt_q;
    reg [`WDRC_CNT_W-1:0] cnt_q;
    reg [`WDRC_CNT_W-1:0] mask;
    reg [7:0] rd_data;

    wire [4:0] key = ctrl_q[`WDRC_KEY_MSB:`WDRC_KEY_LSB];
    wire [2:0] tsel = ctrl_q[`WDRC_TSEL_MSB:`WDRC_TSEL_LSB];
    wire key_on = (key == `WDRC_KEY_ON);
    wire key_bad = !key_on && (key != `WDRC_KEY_OFF);
    wire running = (state_q == S_RUN);
    wire pin_low = reset_pin_en_i && !ext_reset_n_i;
    wire req = wb_cyc_i && wb_stb_i;
    wire wr = req && wb_we_i && wb_ack_o && wb_sel_i[0];
    wire [7:0] wdat = wb_dat_i[7:0];

    // sub-clock source mux: crystal when the select bit is set
    wire tick = fss_q ? lxt_tick_i : internal_low_speed_rc_tick_i;

    // ones in the low bits up to the selected timeout exponent
    always @* begin
        case (tsel)
            3'd0: mask = 18'h000ff;
            3'd1: mask = 18'h003ff;
            3'd2: mask = 18'h00fff;
            3'd3: mask = 18'h03fff;
            3'd4: mask = 18'h07fff;
            3'd5: mask = 18'h0ffff;
            3'd6: mask = 18'h1ffff;
            3'd7: mask = 18'h3ffff;
            default: mask = 18'h3ffff;
        endcase
    end

    // overflow is the carry out of the selected bit
    wire ovf = running && key_on && tick && ((cnt_q & mask) == mask);

    wire fault_fire = fault_pend_q && tick &&
        (fault_cnt_q == `WDRC_FAULT_TICKS);
    wire dev_reset = fault_fire || (ovf && !sleep_i);
    wire cnt_clear = !running || !key_on || clear_wdt_i || halt_i ||
        key_bad || pin_low || ovf;

    // watchdog counter
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= {`WDRC_CNT_W{1'b0}};
        end else if (ce_i) begin
            if (cnt_clear) begin
                cnt_q <= {`WDRC_CNT_W{1'b0}};
            end else if (tick) begin
                cnt_q <= cnt_q + 18'h00001;
            end
        end
    end

    // key fault: flag at once, reset after the sub-clock ticks
    always @(posedge clk_i) begin
        if (rst_i) begin
            fault_pend_q <= 1'b0;
            fault_cnt_q <= 2'd0;
        end else if (ce_i) begin
            if (!running || fault_fire) begin
                fault_pend_q <= 1'b0;
                fault_cnt_q <= 2'd0;
            end else if (key_bad && !fault_pend_q) begin
                fault_pend_q <= 1'b1;
                fault_cnt_q <= 2'd0;
            end else if (fault_pend_q && tick) begin
                // first partial tick plus two whole ones gives 2 to 3
                fault_cnt_q <= fault_cnt_q + 2'd1;
            end
        end
    end

    // reset sequencer
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= S_DELAY;
            dly_q <= POR_DLY;
            sys_rst_o <= 1'b1;
            port_init_o <= 1'b1;
        end else if (ce_i) begin
            case (state_q)
                S_RUN: begin
                    if (pin_low) begin
                        state_q <= S_HOLD;
                        sys_rst_o <= 1'b1;
                    end else if (dev_reset) begin
                        // watchdog resets restart like a pin reset
                        state_q <= S_DELAY;
                        dly_q <= EXT_DLY;
                        sys_rst_o <= 1'b1;
                    end
                end
                S_HOLD: begin
                    if (!pin_low) begin
                        state_q <= S_DELAY;
                        dly_q <= EXT_DLY;
                    end
                end
                S_DELAY: begin
                    if (pin_low) begin
                        state_q <= S_HOLD;
                    end else if (dly_q <= DLY_ONE) begin
                        state_q <= S_RUN;
                        sys_rst_o <= 1'b0;
                        port_init_o <= 1'b0;
                    end else begin
                        dly_q <= dly_q - DLY_ONE;
                    end
                end
                default: begin
                    state_q <= S_DELAY;
                    dly_q <= EXT_DLY;
                    sys_rst_o <= 1'b1;
                end
            endcase
        end
    end

    // timeout and power-down flags, set wins over clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            timeout_flag_o <= 1'b0;
            power_down_flag_o <= 1'b0;
            pc_sp_rst_o <= 1'b0;
        end else if (ce_i) begin
            pc_sp_rst_o <= ovf && sleep_i;
            if (ovf) begin
                timeout_flag_o <= 1'b1;
            end else if (running && (halt_i || clear_wdt_i)) begin
                timeout_flag_o <= 1'b0;
            end
            if ((ovf && sleep_i) || (running && halt_i)) begin
                power_down_flag_o <= 1'b1;
            end else if (running && clear_wdt_i) begin
                power_down_flag_o <= 1'b0;
            end
        end
    end

    // software registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `WDRC_CTRL_RST;
            key_fault_q <= `WDRC_FLAGS_RST;
            fss_q <= `WDRC_CFG_RST;
        end else if (ce_i) begin
            if (fault_fire) begin
                // a corrupted key must not survive its own reset
                ctrl_q <= `WDRC_CTRL_RST;
            end else if (wr && wb_adr_i == `WDRC_ADR_CTRL) begin
                ctrl_q <= wdat;
            end
            if (key_bad && !fault_pend_q && running) begin
                key_fault_q <= 1'b1;
            end else if (wr && wb_adr_i == `WDRC_ADR_FLAGS &&
                    !wdat[`WDRC_FLAG_KEY]) begin
                key_fault_q <= 1'b0;
            end
            if (wr && wb_adr_i == `WDRC_ADR_CFG) begin
                fss_q <= wdat[`WDRC_CFG_FSS];
            end
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        rd_data = 8'h00;
        case (wb_adr_i)
            `WDRC_ADR_CTRL: rd_data = ctrl_q;
            `WDRC_ADR_FLAGS: rd_data[`WDRC_FLAG_KEY] = key_fault_q;
            `WDRC_ADR_STAT: begin
                rd_data[`WDRC_STAT_TO] = timeout_flag_o;
                rd_data[`WDRC_STAT_PDF] = power_down_flag_o;
                rd_data[`WDRC_STAT_EN] = key_on;
                rd_data[`WDRC_STAT_FAULT] = fault_pend_q;
            end
            `WDRC_ADR_CFG: rd_data[`WDRC_CFG_FSS] = fss_q;
            default: rd_data = 8'h00;
        endcase
    end

    // one wait state: ack rises the cycle after the request appears
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= req && !wb_ack_o;
            if (req && !wb_ack_o) begin
                wb_dat_o <= {24'h000000, rd_data};
            end
        end
    end

endmodule // wdrc_top

// ==== test/tb.sv ====
// self-checking bench for wdrc_top with a small timeout model
// assumes shortened restart delays and bench-made rc ticks
`timescale 1ns/1ns
`define CHK(s, e, a) begin num_checks++; if ((a) !== (e)) begin \
    fails++; $display("[FAIL] %s exp %0h got %0h", s, e, a); end end
module tb;
    localparam EXT = 20;
    localparam POR = 40;
    reg clk_i = 0, rst_i = 1, cyc = 0, we = 0, tick = 0, clr = 0;
    reg halt = 0, slp = 0, pen = 0, pin_n = 1, src = 0;
    reg [3:0] adr = 0;
    reg [31:0] wdat = 0, rd, lfsr = 32'h6fa7a3f3;
    wire [31:0] rdat;
    wire ack, srst, pinit, tof, power_down_flag, pcsp;
    integer fails = 0, num_checks = 0, i, n, w, pcsp_n = 0;
    wdrc_top #(.EXT_DELAY_CYC(EXT), .POR_DELAY_CYC(POR)) wdrc_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .lxt_tick_i(tick & src), .internal_low_speed_rc_tick_i(tick | src), .clear_wdt_i(clr),
        .halt_i(halt), .sleep_i(slp), .reset_pin_en_i(pen),
        .ext_reset_n_i(pin_n), .sys_rst_o(srst), .port_init_o(pinit),
        .pc_sp_rst_o(pcsp), .timeout_flag_o(tof), .power_down_flag_o(power_down_flag));
    initial forever #20 clk_i = ~clk_i;
    // the pc/sp pulse lasts one cycle, so count it as it goes by
    always @(posedge clk_i) begin
        if (pcsp === 1'b1)
            pcsp_n <= pcsp_n + 1;
    end
    function [31:0] step(input [31:0] s);
        step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task give_verdict(input integer extra);
        fails = fails + extra;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task wb(input wr, input [3:0] a, input [7:0] d);
        cyc <= 1;
        we <= wr;
        adr <= a;
        wdat <= {24'h0, d};
        for (w = 0; ack !== 1'b1 && w < 20; w++)
            @(posedge clk_i);
        if (w == 20)
            give_verdict(1);
        rd = rdat;
        cyc <= 0;
        @(posedge clk_i);
    endtask
    // random gaps so ticks do not always line up with the same bus phase
    task ticks(input integer k);
        repeat (k) begin
            tick <= 1;
            @(posedge clk_i);
            tick <= 0;
            lfsr = step(lfsr);
            repeat (1 + lfsr[1:0]) @(posedge clk_i);
        end
        repeat (2) @(posedge clk_i);
    endtask
    task core(input c, input h);
        clr <= c;
        halt <= h;
        @(posedge clk_i);
        clr <= 0;
        halt <= 0;
        @(posedge clk_i);
    endtask
    task run_wait;
        for (w = 0; srst !== 1'b0 && w < 200; w++)
            @(posedge clk_i);
        if (w == 200)
            give_verdict(1);
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        `CHK("por", 2'b11, {srst, pinit})
        run_wait;
        `CHK("por dly", 3'b110, {w > POR - 4, w < POR + 3, pinit})
        wb(0, 4'h0, 8'h0);
        `CHK("ctrl", 32'h53, rd)
        wb(0, 4'h2, 8'h0);
        `CHK("unmapped", 32'h0, rd)
        for (i = 0; i < 3; i++) begin
            n = 1 << (8 + 2 * i);
            wb(1, 4'h0, {5'b01010, i[2:0]});
            core(1, 0);
            ticks(n - 2);
            core(1, 0);
            ticks(n - 1);
            `CHK("early", 1'b0, srst)
            ticks(1);
            `CHK("overflow", 2'b11, {srst, tof})
            run_wait;
        end
        wb(1, 4'h0, 8'ha8);
        ticks(300);
        wb(0, 4'h8, 8'h0);
        `CHK("off", 33'h1, {srst, rd})
        core(0, 1);
        `CHK("halt", 2'b10, {power_down_flag, tof})
        core(1, 0);
        `CHK("clr", 1'b0, power_down_flag)
        wb(1, 4'h0, 8'h50);
        slp <= 1;
        core(0, 1);
        ticks(256);
        `CHK("sleep", 3'b011, {srst, tof, power_down_flag})
        `CHK("sleep pcsp", 1, pcsp_n)
        slp <= 0;
        ticks(200);
        pen <= 1;
        pin_n <= 0;
        repeat (3) @(posedge clk_i);
        `CHK("pin", 1'b1, srst)
        pin_n <= 1;
        run_wait;
        `CHK("pin dly", 3'b110, {w > EXT - 4, w < EXT + 3, pinit})
        wb(1, 4'h0, 8'h50);
        ticks(255);
        `CHK("pin clr", 1'b0, srst)
        ticks(1);
        `CHK("recount", 1'b1, srst)
        run_wait;
        lfsr = step(lfsr);
        wb(1, 4'h0, {lfsr[4:1], lfsr[1], 3'b000});
        ticks(2);
        `CHK("fault early", 1'b0, srst)
        ticks(1);
        `CHK("fault", 1'b1, srst)
        run_wait;
        wb(0, 4'h0, 8'h0);
        `CHK("key restore", 32'h53, rd)
        wb(0, 4'h4, 8'h0);
        `CHK("flag", 32'h1, rd)
        wb(1, 4'h4, 8'hfe);
        wb(0, 4'h4, 8'h0);
        `CHK("flag clr", 32'h0, rd)
        // crystal selected: rc input is held busy so a wrong mux trips early
        wb(1, 4'hc, 8'h01);
        wb(0, 4'hc, 8'h0);
        `CHK("source", 32'h1, rd)
        src <= 1;
        wb(1, 4'h0, 8'h50);
        core(1, 0);
        ticks(255);
        `CHK("lxt early", 1'b0, srst)
        ticks(1);
        `CHK("lxt ovf", 1'b1, srst)
        `CHK("awake pcsp", 1, pcsp_n)
        run_wait;
        give_verdict(0);
    end
endmodule // tb

// ==== test/wdrc_properties.sv ====
// port assertions for wdrc_top, bound below
// assumes ce_i is held high by the surroundings
`timescale 1ns/1ns
module wdrc_chk (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire clear_wdt_i,
    input wire halt_i,
    input wire sleep_i,
    input wire reset_pin_en_i,
    input wire ext_reset_n_i,
    input wire sys_rst_o,
    input wire pc_sp_rst_o,
    input wire timeout_flag_o,
    input wire power_down_flag_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_held;
        sys_rst_o [*8];
    endsequence
    a_ack_once: assert property (wb_cyc_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
    a_flag_bits_zero: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i == 4'h4 |-> wb_dat_o[31:1] == 31'h0) else $error("flags");
    a_halt_flags: assert property (halt_i && !sys_rst_o
        |=> power_down_flag_o && !timeout_flag_o) else $error("halt flags");
    a_clear_pd: assert property (clear_wdt_i && !halt_i && !sleep_i
        && !sys_rst_o |=> !power_down_flag_o) else $error("pd kept");
    a_sleep_pulse: assert property (pc_sp_rst_o |-> timeout_flag_o
        && power_down_flag_o && !sys_rst_o ##1 !pc_sp_rst_o) else $error("pcsp");
    a_pin_resets: assert property (reset_pin_en_i && !ext_reset_n_i
        |-> ##[1:2] sys_rst_o) else $error("pin reset missing");
    a_pin_restart: assert property ($rose(ext_reset_n_i)
        && reset_pin_en_i && sys_rst_o |-> s_held) else $error("short delay");
    a_to_resets: assert property ($rose(timeout_flag_o) && !sleep_i
        |-> sys_rst_o) else $error("timeout without reset");
endmodule // wdrc_chk
bind wdrc_top wdrc_chk wdrc_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .clear_wdt_i(clear_wdt_i),
    .halt_i(halt_i), .sleep_i(sleep_i), .reset_pin_en_i(reset_pin_en_i),
    .ext_reset_n_i(ext_reset_n_i), .sys_rst_o(sys_rst_o),
    .pc_sp_rst_o(pc_sp_rst_o), .timeout_flag_o(timeout_flag_o),
    .power_down_flag_o(power_down_flag_o));
